// file: dv/phy_link_request_status_tb_top.sv
// Purpose: Self-checking bench for the link request and status block.
// Assumes: The phy model answers register reads by itself.
// Notes:   Each scenario task drives the block and judges the result.
`timescale 1ns/1ps
module phy_link_request_status_tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [3:0]  adr   = 4'h0;
  logic [31:0] dat   = 32'h0;
  logic        cs    = 1'b0;
  logic [31:0] rdat;
  logic        ack;
  logic        phy_clk;
  logic [1:0]  ctl;
  logic [1:0]  pd;
  logic        req_line;
  logic        arb;
  logic        fgap;
  int          mismatches = 0;
  int          tests_run  = 0;
  int          cycles     = 0;
  int          n_arb      = 0;
  int          n_fair     = 0;
  int          n0;
  plrs_link_request dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .phy_clk_i(phy_clk),
    .interface_control_pair_i(ctl), .phy_data_i(pd),
    .cycle_start_seen_i(cs), .link_request_line_o(req_line),
    .busy_retry_gap_o(arb), .iso_cycle_done_o(fgap));
  plrs_phy_model phy (.phy_clk_o(phy_clk), .ctl_o(ctl), .data_o(pd),
                      .link_request_line_i(req_line));
  // A 50 ns system clock.
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  // Pulse counters; the ceiling is far above the few thousand needed.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (arb === 1'b1) n_arb <= n_arb + 1;
    if (fgap === 1'b1) n_fair <= n_fair + 1;
    if (cycles == 60000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Classic single cycle; read data is taken at the ack edge.
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 100);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n == 100) mismatches++;
  endtask
  // Reads a word until the given bit is set, under a bound.
  task automatic poll(input logic [3:0] a, input int b,
                      output logic [31:0] q);
    int n;
    n = 0;
    do begin
      wb(1'b0, a, 32'h0, q);
      n++;
    end while (q[b] !== 1'b1 && n < 100);
  endtask
  task automatic go(input logic [2:0] t, input logic [1:0] s,
                    input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    n0 = phy.streams;
    wb(1'b1, plrs_pkg::OFS_REQ, {1'b1, 7'h0, d, 4'h0, a, 2'h0, s, 1'b0, t}, q);
  endtask
  // Waits for a new stream, then leaves room before the next request.
  task automatic wait_stream(input int lim);
    int n;
    n = 0;
    while (phy.streams == n0 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    repeat (40) @(posedge clk_i);
  endtask
  task automatic t_status();
    int a0;
    int f0;
    a0 = n_arb;
    f0 = n_fair;
    phy.send_status(16'h0001, plrs_pkg::ST_SHORT);
    repeat (40) @(posedge clk_i);
    chk("arb gap", 1, n_arb - a0);
    chk("fair gap", 0, n_fair - f0);
    phy.send_status(16'h0002, plrs_pkg::ST_SHORT);
    repeat (40) @(posedge clk_i);
    chk("fair gap", 1, n_fair - f0);
  endtask
  // Fair and priority at each speed; iso waits for a cycle start.
  task automatic t_bus();
    logic [2:0] ty [2] = '{plrs_pkg::REQ_PRIORITY, plrs_pkg::REQ_FAIR};
    logic [1:0] sp [3] = '{plrs_pkg::SPD_100, plrs_pkg::SPD_200,
                           plrs_pkg::SPD_400};
    for (int i = 0; i < 2; i++) begin
      for (int j = 0; j < 3; j++) begin
        go(ty[i], sp[j], 4'h0, 8'h00);
        wait_stream(3000);
        chk("bus", {1'b0, sp[j], ty[i], 1'b1}, phy.last[6:0]);
      end
    end
    go(plrs_pkg::REQ_ISO, plrs_pkg::SPD_200, 4'h0, 8'h00);
    wait_stream(300);
    chk("iso early", n0, phy.streams);
    cs <= 1'b1;
    wait_stream(3000);
    cs <= 1'b0;
    chk("iso", 7'h13, phy.last[6:0]);
    chk("iso pend", 0, phy.iso_pend);
  endtask
  task automatic t_reserved();
    logic [31:0] q;
    for (int t = 6; t < 8; t++) begin
      go(3'(t), plrs_pkg::SPD_100, 4'h0, 8'h00);
      wait_stream(300);
      chk("reserved", n0, phy.streams);
    end
    wb(1'b0, 4'h2, 32'h0, q);
    chk("unmapped", 32'h0, q);
  endtask
  // Write while a packet arrives, then read back via full status.
  task automatic t_regs();
    logic [31:0] q;
    phy.drive_ctl(plrs_pkg::CTL_RECV);
    go(plrs_pkg::REQ_REG_WR, plrs_pkg::SPD_100, 4'h5, 8'ha5);
    wait_stream(3000);
    chk("wr", 17'h0a55b, phy.last);
    phy.drive_ctl(plrs_pkg::CTL_IDLE);
    go(plrs_pkg::REQ_REG_RD, plrs_pkg::SPD_100, 4'h5, 8'h00);
    wait_stream(3000);
    chk("rd", 9'h059, phy.last[8:0]);
    poll(plrs_pkg::OFS_PHYREG, 12, q);
    chk("phyreg", 32'h15a5, q);
    wb(1'b0, plrs_pkg::OFS_STATUS, 32'h0, q);
    chk("status", 32'ha550, q);
  endtask
  // A receive after a fair request loses it; the block then reissues it once idle.
  task automatic t_lost();
    logic [31:0] q;
    phy.auto_grant = 1'b0;
    go(plrs_pkg::REQ_FAIR, plrs_pkg::SPD_400, 4'h0, 8'h00);
    wait_stream(3000);
    phy.drive_ctl(plrs_pkg::CTL_RECV);
    poll(plrs_pkg::OFS_REQ, 24, q);
    chk("lost", 1'b1, q[24]);
    n0 = phy.streams;
    phy.auto_grant = 1'b1;
    phy.drive_ctl(plrs_pkg::CTL_IDLE);
    wait_stream(3000);
    chk("reissue", n0 + 1, phy.streams);
  endtask
  // Take-over for an addressed packet goes out during the receive.
  task automatic t_take();
    logic [31:0] q;
    wb(1'b1, plrs_pkg::OFS_CTRL, 32'h4, q);
    phy.drive_ctl(plrs_pkg::CTL_RECV);
    repeat (10) @(posedge clk_i);
    go(plrs_pkg::REQ_TAKEOVER, plrs_pkg::SPD_100, 4'h0, 8'h00);
    wait_stream(3000);
    chk("take", 7'h01, phy.last[6:0]);
    phy.drive_ctl(plrs_pkg::CTL_IDLE);
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Reset for 20 cycles, then every scenario in turn.
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_status();
    t_bus();
    t_reserved();
    t_regs();
    t_lost();
    t_take();
    tally_and_finish();
  end
endmodule

// file: dv/plrs_phy_model.sv
// Purpose: Behavioural phy on the far side of the request line.
// Assumes: The interface clock runs free at a 400 ns period.
// Notes:   The bench sets the control code through drive_ctl.
`timescale 1ns/1ps
module plrs_phy_model (
  output logic       phy_clk_o,
  output logic [1:0] ctl_o,
  output logic [1:0] data_o,
  input  wire logic  link_request_line_i
);
  logic [16:0] sh;
  logic [16:0] last;
  logic [7:0]  regs [16];
  logic [3:0]  rd_adr;
  logic        rd_pend = 1'b0;
  int          cnt     = 0;
  int          len     = 7;
  int          streams = 0;
  logic        auto_grant = 1'b1;
  logic        gr_pend    = 1'b0;
  logic        iso_pend   = 1'b0;
  logic        cut        = 1'b0;
  // The clock free runs; control idles until the bench says otherwise.
  initial begin
    ctl_o     = plrs_pkg::CTL_IDLE;
    data_o    = 2'h0;
    phy_clk_o = 1'b0;
    forever #200 phy_clk_o = ~phy_clk_o;
  end
  // One request bit per rising edge; the type decides the length.
  always @(posedge phy_clk_o) begin
    if (cnt > 0 || link_request_line_i === 1'b1) begin
      sh[cnt] = link_request_line_i;
      cnt     = cnt + 1;
      len     = (sh[3:1] == plrs_pkg::REQ_REG_RD) ? 9 :
                (sh[3:1] == plrs_pkg::REQ_REG_WR) ? 17 : 7;
      if (cnt > 3 && cnt == len) begin
        last    = sh;
        streams = streams + 1;
        cnt     = 0;
        rd_adr  = sh[7:4];
        rd_pend = (sh[3:1] == plrs_pkg::REQ_REG_RD);
        gr_pend = (sh[3:1] < plrs_pkg::REQ_REG_RD);
        iso_pend = (sh[3:1] == plrs_pkg::REQ_ISO);
        if (sh[3:1] == plrs_pkg::REQ_REG_WR) begin
          regs[sh[7:4]] = sh[15:8];
        end
      end
    end
  end
  // Codes change on the falling edge, well clear of the sampling edge.
  task automatic drive_ctl(input logic [1:0] c);
    @(negedge phy_clk_o);
    ctl_o = c;
  endtask
  // Two status bits per clock, bit 0 on line 0, then one idle clock.
  task automatic send_status(input logic [15:0] v, input int n);
    for (int k = 0; k < n; k += 2) begin
      @(negedge phy_clk_o);
      if (ctl_o == plrs_pkg::CTL_RECV) begin
        cut = 1'b1;
      end else begin
        ctl_o  = plrs_pkg::CTL_STATUS;
        data_o = v[k+:2];
      end
    end
    @(negedge phy_clk_o);
    ctl_o  = plrs_pkg::CTL_IDLE;
    data_o = ~data_o;
  endtask
  // A register read is answered by a full status stream once idle.
  always @(posedge phy_clk_o) begin
    if (rd_pend && ctl_o == plrs_pkg::CTL_IDLE) begin
      rd_pend = 1'b0;
      // A status cut by a receive is sent again until it gets through.
      do begin
        cut = 1'b0;
        send_status({regs[rd_adr], rd_adr, 4'h0}, 16);
      end while (cut);
    end
  end
  // A bus request is granted for one clock once the control pair idles.
  always @(posedge phy_clk_o) begin
    if (gr_pend && auto_grant && ctl_o == plrs_pkg::CTL_IDLE) begin
      gr_pend = 1'b0;
      @(negedge phy_clk_o);
      ctl_o = plrs_pkg::CTL_GRANT;
      @(negedge phy_clk_o);
      ctl_o    = plrs_pkg::CTL_IDLE;
      iso_pend = 1'b0;
    end
  end
endmodule

// file: logic/plrs_link_request.sv
// Purpose: Link end of the phy request line and status transfer receiver.
// Assumes: Phy clock runs slower than clk_i; pins pass two flip-flops.
// Notes:   Registers are reached over classic Wishbone, 32-bit data.
//
// The implementer's own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
module plrs_link_request (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        phy_clk_i,
  input  wire logic [1:0]  interface_control_pair_i,
  input  wire logic [1:0]  phy_data_i,
  input  wire logic        cycle_start_seen_i,
  output logic             link_request_line_o,
  output logic             busy_retry_gap_o,
  output logic             iso_cycle_done_o
);
  typedef enum logic [1:0] {
    PLRS_IDLE = 2'b00,
    PLRS_WAIT = 2'b01,
    PLRS_SEND = 2'b10,
    PLRS_HOLD = 2'b11
  } plrs_state_e;

  // Two-flop synchronisers for every phy pin.
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic       clk_prev;
  always_ff @(posedge clk_i) begin
    sync1 <= {phy_clk_i, interface_control_pair_i, phy_data_i[0]};
    sync2 <= sync1;
  end
  logic [1:0] data_sync1;
  logic       data_hi;
  always_ff @(posedge clk_i) begin
    data_sync1 <= {phy_data_i[1], 1'b0};
    data_hi    <= data_sync1[1];
  end

  // Phy clock rising edges become one-cycle enables.
  wire        pclk = sync2[3];
  wire [1:0]  ctl  = sync2[2:1];
  wire [1:0]  dat  = {data_hi, sync2[0]};
  wire        tick = pclk & ~clk_prev;
  always_ff @(posedge clk_i) begin
    if (rst_i) clk_prev <= 1'b0;
    else       clk_prev <= pclk;
  end

  // Registers written by software, then request tracking and status receiver state.
  logic        cycle_master;
  logic        hdr_bad;
  logic        addressed;
  logic [2:0]  req_type;
  logic [1:0]  req_speed;
  logic [3:0]  req_addr;
  logic [7:0]  req_data;
  logic        pending;
  logic        lost;
  logic        iso_armed;
  logic [15:0] status;
  logic [3:0]  status_cnt;
  logic        prev_ctl_status;
  logic [7:0]  phyreg_data;
  logic [3:0]  phyreg_addr;
  logic        phyreg_valid;

  plrs_state_e state;
  plrs_state_e next_state;
  logic [16:0] shreg;
  logic [4:0]  bits_left;
  logic [3:0]  rel_cnt;
  logic        relaunch;

  wire ctl_idle  = ctl == plrs_pkg::CTL_IDLE;
  wire ctl_recv  = ctl == plrs_pkg::CTL_RECV;
  wire ctl_stat  = ctl == plrs_pkg::CTL_STATUS;
  wire ctl_grant = ctl == plrs_pkg::CTL_GRANT;
  wire is_arb    = req_type == plrs_pkg::REQ_PRIORITY |
                   req_type == plrs_pkg::REQ_FAIR;
  wire is_reg    = req_type[2];
  wire is_take   = req_type == plrs_pkg::REQ_TAKEOVER;
  wire is_iso    = req_type == plrs_pkg::REQ_ISO;

  // Wishbone decode and access strobes.
  wire acc    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr     = acc & wb_we_i;
  wire wr_ctl = wr & wb_adr_i == plrs_pkg::OFS_CTRL & wb_sel_i[0];
  wire wr_req = wr & wb_adr_i == plrs_pkg::OFS_REQ & wb_sel_i[3];
  // Reserved types 110 and 111 never reach the sequencer.
  wire [2:0] wr_type = wb_dat_i[plrs_pkg::F_TYPE +: 3];
  wire go     = wr_req & wb_dat_i[plrs_pkg::F_GO] & ~pending &
                (wr_type != 3'h6) & (wr_type != 3'h7);
  wire [31:0] rd_mux =
    wb_adr_i == plrs_pkg::OFS_CTRL ?
      {29'h0, addressed, hdr_bad, cycle_master} :
    wb_adr_i == plrs_pkg::OFS_REQ ?
      {pending, 6'h0, lost, req_data, 4'h0, req_addr, 2'h0, req_speed,
       1'b0, req_type} :
    wb_adr_i == plrs_pkg::OFS_STATUS ? {16'h0, status} :
    wb_adr_i == plrs_pkg::OFS_PHYREG ?
      {19'h0, phyreg_valid, phyreg_addr, phyreg_data} : 32'h0;

  // Bus answer is one cycle after the request; unmapped reads give zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= acc;
      wb_dat_o <= acc ? rd_mux : 32'h0;
    end
  end

  // Control register; the cycle master flag forces priority type.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cycle_master <= 1'b0;
      hdr_bad      <= 1'b0;
      addressed    <= 1'b0;
    end else if (wr_ctl) begin
      cycle_master <= wb_dat_i[plrs_pkg::F_CYCLE_MASTER];
      hdr_bad      <= wb_dat_i[plrs_pkg::F_HDR_BAD];
      addressed    <= wb_dat_i[plrs_pkg::F_ADDRESSED];
    end
  end

  // Stream image, bit 0 is the start bit and goes out first.
  // A read carries no data, so bit 8 must be its stop bit.
  wire [7:0]  img_data = req_type == plrs_pkg::REQ_REG_WR ? req_data : 8'h0;
  wire [16:0] image =
    is_reg ? {1'b0, img_data, req_addr, req_type, 1'b1} :
             {10'h0, 1'b0, req_speed, req_type, 1'b1};
  wire [4:0] image_len =
    req_type == plrs_pkg::REQ_REG_WR ? plrs_pkg::LEN_WR :
    req_type == plrs_pkg::REQ_REG_RD ? plrs_pkg::LEN_RD :
    plrs_pkg::LEN_BUS;

  // Iso allowed only once a cycle start was seen, until the fair gap.
  wire iso_ok   = iso_armed | cycle_start_seen_i;
  // Take-over only during reception of a packet for us.
  wire take_ok  = ctl_recv & addressed;
  wire start_ok = is_reg | (is_arb & ctl_idle) |
                  (is_iso & iso_ok) | (is_take & take_ok);

  // Sequencer: wait for a legal moment, shift, then watch for loss.
  always_comb begin
    next_state = state;
    unique case (state)
      PLRS_IDLE: if (pending) next_state = PLRS_WAIT;
      PLRS_WAIT: if (tick & start_ok) next_state = PLRS_SEND;
      PLRS_SEND: if (tick & bits_left == 5'h1) next_state = PLRS_HOLD;
      PLRS_HOLD: if (~pending) next_state = PLRS_IDLE;
    endcase
    // A lost fair or priority request waits for the next idle again.
    if (relaunch) next_state = PLRS_WAIT;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state     <= PLRS_IDLE;
      shreg     <= 17'h0;
      bits_left <= 5'h0;
    end else begin
      state <= next_state;
      if (state == PLRS_WAIT & next_state == PLRS_SEND) begin
        shreg     <= image;
        bits_left <= image_len;
      end else if (state == PLRS_SEND & tick) begin
        shreg     <= {1'b0, shreg[16:1]};
        bits_left <= bits_left - 5'h1;
      end
    end
  end

  // Request line drives the low bit of the shifter while sending.
  always_ff @(posedge clk_i) begin
    if (rst_i) link_request_line_o <= 1'b0;
    else link_request_line_o <= next_state == PLRS_SEND &
      (state == PLRS_WAIT ? image[0] : (tick ? shreg[1] : shreg[0]));
  end

  // Pending request, loss tracking and release timer.
  wire sent   = state == PLRS_HOLD;
  wire lose   = (state == PLRS_SEND | sent) & ctl_recv &
                ~is_reg & ~is_take;
  wire drop   = is_take & (state != PLRS_IDLE) & ~ctl_recv &
                ~ctl_grant & hdr_bad;
  wire done   = sent & (is_reg | (ctl_grant & ~hdr_bad) |
                (is_take & rel_cnt == 4'h1));
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pending <= 1'b0;
      lost    <= 1'b0;
      rel_cnt <= 4'h0;
    end else begin
      if (go) begin
        pending <= 1'b1;
        lost    <= 1'b0;
      end else if (done | drop) begin
        pending <= 1'b0;
      end
      if (lose & is_arb) lost <= 1'b1;
      if (sent & is_take & ctl_grant & hdr_bad & rel_cnt == 4'h0)
        rel_cnt <= 4'(plrs_pkg::RELEASE_CYC);
      else if (rel_cnt != 4'h0)
        rel_cnt <= rel_cnt - 4'h1;
    end
  end

  // Request fields latch on go; cycle master forces priority.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_type  <= plrs_pkg::REQ_FAIR;
      req_speed <= plrs_pkg::SPD_100;
      req_addr  <= 4'h0;
      req_data  <= 8'h0;
    end else if (go) begin
      req_type  <= cycle_master ? plrs_pkg::REQ_PRIORITY :
                   wb_dat_i[plrs_pkg::F_TYPE +: 3];
      req_speed <= wb_dat_i[plrs_pkg::F_SPEED +: 2] == 2'h3 ?
                   plrs_pkg::SPD_400 :
                   wb_dat_i[plrs_pkg::F_SPEED +: 2];
      req_addr  <= wb_dat_i[plrs_pkg::F_ADDR +: 4];
      req_data  <= wb_dat_i[plrs_pkg::F_DATA +: 8];
    end
  end

  // Status receiver: two bits per phy clock while code 01 stands.
  // A lost fair/priority goes back to waiting for the next idle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status          <= 16'h0;
      status_cnt      <= 4'h0;
      prev_ctl_status <= 1'b0;
      phyreg_data     <= 8'h0;
      phyreg_addr     <= 4'h0;
      phyreg_valid    <= 1'b0;
      iso_armed       <= 1'b0;
      busy_retry_gap_o <= 1'b0;
      iso_cycle_done_o <= 1'b0;
    end else begin
      busy_retry_gap_o <= 1'b0;
      iso_cycle_done_o <= 1'b0;
      if (cycle_start_seen_i) iso_armed <= 1'b1;
      // Clear comes first so a completing stream in the same cycle wins.
      if (wr_req) phyreg_valid <= 1'b0;
      if (tick) begin
        prev_ctl_status <= ctl_stat;
        if (ctl_stat) begin
          status[{status_cnt[2:0], 1'b0} +: 2] <= dat;
          status_cnt <= status_cnt + 4'h1;
          if (status_cnt == 4'h1) begin
            busy_retry_gap_o <= status[plrs_pkg::ST_ARB_RESET];
            iso_cycle_done_o <= status[plrs_pkg::ST_FAIR_GAP];
            if (status[plrs_pkg::ST_FAIR_GAP]) iso_armed <= 1'b0;
          end
          if (status_cnt == 4'h7) begin
            phyreg_addr  <= status[7:4];
            phyreg_data  <= {dat, status[13:8]};
            phyreg_valid <= 1'b1;
          end
        end else begin
          status_cnt <= 4'h0;
        end
      end
    end
  end

  // Loss of a fair or priority request returns the sequencer to waiting.
  assign relaunch = lose & is_arb;

  AST_LOST_FLAG: assert property (@(posedge clk_i) disable iff (rst_i)
    lose & is_arb |=> lost) else $error("loss not flagged");
  AST_NO_RESERVED: assert property (@(posedge clk_i) disable iff (rst_i)
    pending |-> req_type != 3'h6 && req_type != 3'h7)
    else $error("reserved type");
  AST_ARB_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
    state == PLRS_WAIT && next_state == PLRS_SEND && is_arb |-> ctl_idle)
    else $error("arb without idle");
  AST_START_BIT: assert property (@(posedge clk_i) disable iff (rst_i)
    state == PLRS_WAIT && next_state == PLRS_SEND |=> link_request_line_o)
    else $error("no start bit");
  AST_CM_PRIO: assert property (@(posedge clk_i) disable iff (rst_i)
    go && cycle_master |=> req_type == plrs_pkg::REQ_PRIORITY)
    else $error("cycle master not priority");
  AST_TAKE_RECV: assert property (@(posedge clk_i) disable iff (rst_i)
    state == PLRS_WAIT && next_state == PLRS_SEND && is_take |-> ctl_recv)
    else $error("take-over outside receive");
  AST_ISO_OK: assert property (@(posedge clk_i) disable iff (rst_i)
    state == PLRS_WAIT && next_state == PLRS_SEND && is_iso |-> iso_ok)
    else $error("iso before cycle start");
  AST_STOP_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
    state == PLRS_HOLD |-> !link_request_line_o)
    else $error("line high after stop");
  COV_REG: cover property (@(posedge clk_i) go && wb_dat_i[2]);
  COV_LOST: cover property (@(posedge clk_i) relaunch);
  COV_STATUS: cover property (@(posedge clk_i) phyreg_valid);
endmodule

// file: logic/plrs_pkg.sv
// Purpose: Constants for the link-side phy request and status logic.
// Assumes: Register map offsets are byte addresses on a 32-bit bus.
// Notes:   Codes, offsets, positions and cycle counts live here; reserved types 110 and 111 are in the logic.
package plrs_pkg;
  // Request-type codes carried in stream bits 1 to 3.
  localparam logic [2:0] REQ_TAKEOVER = 3'h0;
  localparam logic [2:0] REQ_ISO      = 3'h1;
  localparam logic [2:0] REQ_PRIORITY = 3'h2;
  localparam logic [2:0] REQ_FAIR     = 3'h3;
  localparam logic [2:0] REQ_REG_RD   = 3'h4;
  localparam logic [2:0] REQ_REG_WR   = 3'h5;
  // Speed codes carried in stream bits 4 and 5.
  localparam logic [1:0] SPD_100 = 2'h0;
  localparam logic [1:0] SPD_200 = 2'h1;
  localparam logic [1:0] SPD_400 = 2'h2;
  // Control pair codes driven by the phy.
  localparam logic [1:0] CTL_IDLE   = 2'h0;
  localparam logic [1:0] CTL_STATUS = 2'h1;
  localparam logic [1:0] CTL_RECV   = 2'h2;
  localparam logic [1:0] CTL_GRANT  = 2'h3;
  // Stream lengths in bits, start and stop included.
  localparam logic [4:0] LEN_BUS = 5'h07;
  localparam logic [4:0] LEN_RD  = 5'h09;
  localparam logic [4:0] LEN_WR  = 5'h11;
  // Status stream layout.
  localparam int ST_LEN       = 16;
  localparam int ST_SHORT     = 4;
  localparam int ST_ARB_RESET = 0;
  localparam int ST_FAIR_GAP  = 1;
  localparam int ST_BUS_RESET = 2;
  localparam int ST_PHY_IRQ   = 3;
  // Release delay after a received packet with a bad header check.
  localparam int CLK_PERIOD_NS = 50;
  localparam int RELEASE_NS    = 160;
  localparam int RELEASE_CYC   =
    (RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Register byte offsets.
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_REQ    = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam logic [3:0] OFS_PHYREG = 4'hc;
  // Request register field positions.
  localparam int F_TYPE  = 0;
  localparam int F_SPEED = 4;
  localparam int F_ADDR  = 8;
  localparam int F_DATA  = 16;
  localparam int F_GO    = 31;
  // Control register field positions.
  localparam int F_CYCLE_MASTER = 0;
  localparam int F_HDR_BAD      = 1;
  localparam int F_ADDRESSED    = 2;
endpackage
